// *** verilog/dsm_pkg.sv ***
// Package with register map, field positions and encodings of the data signal modulator.
`default_nettype none
package dsm_pkg;
    // Register byte addresses on the APB bus.
    localparam logic [11:0] ADDR_CONTROL_0 = 12'h000;
    localparam logic [11:0] ADDR_CONTROL_1 = 12'h004;
    localparam logic [11:0] ADDR_SOURCE    = 12'h008;

    // Register reset values.
    localparam logic [7:0] RESET_CONTROL_0 = 8'h00;
    localparam logic [7:0] RESET_CONTROL_1 = 8'h00;
    localparam logic [4:0] RESET_SOURCE    = 5'h00;

    // Field positions in control register 0.
    localparam int CTL0_ENABLE  = 7;
    localparam int CTL0_OUTPUT  = 5;
    localparam int CTL0_INVERT  = 4;
    localparam int CTL0_SW_BIT  = 0;

    // Field positions in control register 1.
    localparam int CTL1_HIGH_INVERT = 5;
    localparam int CTL1_HIGH_SYNC   = 4;
    localparam int CTL1_LOW_INVERT  = 1;
    localparam int CTL1_LOW_SYNC    = 0;

    // Writable bit masks; other bits read as zero, except control 0 bit 5, which reads the output level.
    localparam logic [7:0] MASK_CONTROL_0 = 8'h91;
    localparam logic [7:0] MASK_CONTROL_1 = 8'h33;
    localparam int         SOURCE_WIDTH   = 5;

    // Modulator source codes.
    localparam logic [4:0] SRC_PIN           = 5'h00;
    localparam logic [4:0] SRC_SOFTWARE      = 5'h01;
    localparam logic [4:0] SRC_SERIAL_TX     = 5'h02;
    localparam logic [4:0] SRC_SYNC_SERIAL   = 5'h03;
    localparam logic [4:0] SRC_SPI_DATA      = 5'h04;
    localparam logic [4:0] SRC_FIRST_RESERVE = 5'h1B;
    localparam int         SRC_OTHER_LOW     = 5;
    localparam int         SRC_OTHER_HIGH    = 26;

    // Active carrier state.
    typedef enum logic [1:0] {
        DSM_CARRIER_LOW  = 2'b01,
        DSM_CARRIER_HIGH = 2'b10
    } dsm_carrier_e;
endpackage : dsm_pkg

`default_nettype wire

// *** verilog/dsm_ctrl.sv ***
// Data signal modulator control, source selection, carrier mixing and APB register slave.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RULE_01 - Enable bit 7 mixes; clear means no output.
// RULE_02 - Status bit 5 shows present output level.
// RULE_03 - Readback sampled by clock; fast signals unreliable.
// RULE_04 - Bit 4 inverts output, idle high.
// RULE_05 - Software bit: one high carrier, zero low.
// RULE_06 - Software bit works only under code 00001.
// RULE_07 - Unsynchronised carrier switching may truncate pulses.
// RULE_08 - Five-bit field selects modulator input source.
// RULE_09 - Control registers clear on every reset; code clears them on rst_b only, not on por_bor_b.
// RULE_10 - Source select survives resets except power-on; code also clears it on brown-out (por_bor_b).
// RULE_11 - Unused bits read zero, ignore writes.
// RULE_12 - Modulator level picks high or low carrier.
// RULE_13 - Disable grounds carriers, uses software bit.
// RULE_14 - Separate polarity bits invert each carrier.
// RULE_15 - Sync lets carrier pulse end before switching.
// RULE_16 - Reserved source codes give constant low modulator.
module dsm_ctrl (
    // Clock and resets.
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        por_bor_b,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Carriers, already selected upstream.
    input  wire logic        high_carrier,
    input  wire logic        low_carrier,
    // Modulator sources.
    input  wire logic        pin_routed_modulator_input,
    input  wire logic        serial_transmit_line,
    input  wire logic        sync_serial_data_line,
    input  wire logic        spi_serial_data_line,
    input  wire logic [26:5] other_modulator_sources,
    // Modulated result.
    output logic             modulated_pin_signal
);

    logic [7:0]                           modulation_control_0;
    logic [7:0]                           modulation_control_1;
    logic [dsm_pkg::SOURCE_WIDTH-1:0]     modulator_source_select;
    dsm_pkg::dsm_carrier_e                active_carrier;
    dsm_pkg::dsm_carrier_e                next_active_carrier;
    logic                                 enable;
    logic                                 software_level_source;
    logic                                 result_invert;
    logic                                 high_carrier_invert;
    logic                                 high_carrier_sync_enable;
    logic                                 low_carrier_invert;
    logic                                 low_carrier_sync_enable;
    logic                                 modulator_level;
    logic                                 high_path;
    logic                                 low_path;
    logic                                 mixed;
    logic                                 next_output;
    logic                                 write_access;
    logic                                 read_setup;
    logic                                 mapped;
    logic [7:0]                           read_value;

    // Register decode, shared by the write path and the error response.
    function automatic logic is_mapped(input logic [11:0] addr);
        return (addr == dsm_pkg::ADDR_CONTROL_0) || (addr == dsm_pkg::ADDR_CONTROL_1) ||
               (addr == dsm_pkg::ADDR_SOURCE);
    endfunction : is_mapped

    // Modulator source multiplexer.
    function automatic logic select_modulator(
        input logic [4:0]  code,
        input logic        sw_bit,
        input logic        pin_in,
        input logic        tx_in,
        input logic        sync_in,
        input logic        spi_in,
        input logic [26:5] others
    );
        logic level;
        level = 1'b0;
        if (code >= dsm_pkg::SRC_FIRST_RESERVE) begin
            level = 1'b0;                                                    // [RULE_16]
        end else begin
            case (code)
                dsm_pkg::SRC_PIN:         level = pin_in;                    // [RULE_08]
                dsm_pkg::SRC_SOFTWARE:    level = sw_bit;                    // [RULE_06]
                dsm_pkg::SRC_SERIAL_TX:   level = tx_in;
                dsm_pkg::SRC_SYNC_SERIAL: level = sync_in;
                dsm_pkg::SRC_SPI_DATA:    level = spi_in;
                default:                  level = others[code];
            endcase
        end
        return level;
    endfunction : select_modulator

    assign enable                   = modulation_control_0[dsm_pkg::CTL0_ENABLE];
    assign software_level_source    = modulation_control_0[dsm_pkg::CTL0_SW_BIT];
    assign result_invert            = modulation_control_0[dsm_pkg::CTL0_INVERT];
    assign high_carrier_invert      = modulation_control_1[dsm_pkg::CTL1_HIGH_INVERT];
    assign high_carrier_sync_enable = modulation_control_1[dsm_pkg::CTL1_HIGH_SYNC];
    assign low_carrier_invert       = modulation_control_1[dsm_pkg::CTL1_LOW_INVERT];
    assign low_carrier_sync_enable  = modulation_control_1[dsm_pkg::CTL1_LOW_SYNC];

    // Disabled: carriers grounded, modulator from the software bit; stored selections stay.
    always_comb begin
        if (enable) begin
            modulator_level = select_modulator(modulator_source_select, software_level_source,
                                               pin_routed_modulator_input, serial_transmit_line,
                                               sync_serial_data_line, spi_serial_data_line,
                                               other_modulator_sources);          // [RULE_08]
            high_path = high_carrier ^ high_carrier_invert;                       // [RULE_14]
            low_path  = low_carrier ^ low_carrier_invert;                         // [RULE_14]
        end else begin
            modulator_level = software_level_source;                              // [RULE_13]
            high_path = 1'b0;                                                     // [RULE_13]
            low_path  = 1'b0;                                                     // [RULE_13]
        end
    end

    // Carrier switch; with sync the running pulse is let fall before the switch.
    always_comb begin
        next_active_carrier = active_carrier;
        case (active_carrier)
            dsm_pkg::DSM_CARRIER_HIGH: begin
                if (!modulator_level && (!high_carrier_sync_enable || !high_path)) begin
                    next_active_carrier = dsm_pkg::DSM_CARRIER_LOW;               // [RULE_15] [RULE_07]
                end
            end
            dsm_pkg::DSM_CARRIER_LOW: begin
                if (modulator_level && (!low_carrier_sync_enable || !low_path)) begin
                    next_active_carrier = dsm_pkg::DSM_CARRIER_HIGH;              // [RULE_15] [RULE_07]
                end
            end
            default: next_active_carrier = dsm_pkg::DSM_CARRIER_LOW;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            active_carrier <= dsm_pkg::DSM_CARRIER_LOW;
        end else begin
            active_carrier <= next_active_carrier;
        end
    end

    // Mixing uses the carrier chosen by the modulator level.
    assign mixed       = (active_carrier == dsm_pkg::DSM_CARRIER_HIGH) ? high_path : low_path; // [RULE_12] [RULE_05]
    assign next_output = (enable & mixed) ^ result_invert;                               // [RULE_01] [RULE_04]

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            modulated_pin_signal <= 1'b0;
        end else begin
            modulated_pin_signal <= next_output;
        end
    end

    // APB slave: read data is captured in the setup cycle, so every access has no wait state.
    assign write_access = psel & penable & pwrite & mapped;
    assign read_setup   = psel & ~penable & ~pwrite;
    assign mapped       = is_mapped(paddr);
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & ~mapped;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            modulation_control_0 <= dsm_pkg::RESET_CONTROL_0;                       // [RULE_09]
            modulation_control_1 <= dsm_pkg::RESET_CONTROL_1;                       // [RULE_09]
        end else if (write_access && paddr == dsm_pkg::ADDR_CONTROL_0) begin
            modulation_control_0 <= pwdata[7:0] & dsm_pkg::MASK_CONTROL_0;          // [RULE_11]
        end else if (write_access && paddr == dsm_pkg::ADDR_CONTROL_1) begin
            modulation_control_1 <= pwdata[7:0] & dsm_pkg::MASK_CONTROL_1;          // [RULE_11]
        end
    end

    // Only a power-on or brown-out reset clears the source select.
    always_ff @(posedge clk) begin
        if (!por_bor_b) begin
            modulator_source_select <= dsm_pkg::RESET_SOURCE;                        // [RULE_10]
        end else if (write_access && paddr == dsm_pkg::ADDR_SOURCE) begin
            modulator_source_select <= pwdata[dsm_pkg::SOURCE_WIDTH-1:0];            // [RULE_11]
        end
    end

    always_comb begin
        read_value = 8'h00;
        case (paddr)
            dsm_pkg::ADDR_CONTROL_0: begin
                read_value = modulation_control_0;
                read_value[dsm_pkg::CTL0_OUTPUT] = modulated_pin_signal;            // [RULE_02] [RULE_03]
            end
            dsm_pkg::ADDR_CONTROL_1: read_value = modulation_control_1;
            dsm_pkg::ADDR_SOURCE:    read_value = {3'b000, modulator_source_select};  // [RULE_11]
            default:                 read_value = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (read_setup) begin
            prdata <= {24'h00_0000, read_value};
        end
    end

    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_ctl0_write(logic [7:0] v);
        psel && penable && pwrite && paddr == dsm_pkg::ADDR_CONTROL_0 && pwdata[7:0] == v;
    endsequence

    property p_disabled_idle;
        !enable |=> modulated_pin_signal == $past(result_invert);
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("disabled output not idle"); // [RULE_01]

    property p_readback;
        psel && !penable && !pwrite && paddr == dsm_pkg::ADDR_CONTROL_0
            |=> prdata[dsm_pkg::CTL0_OUTPUT] == $past(modulated_pin_signal);
    endproperty
    a_readback: assert property (p_readback) else $error("output readback wrong"); // [RULE_02]

    property p_invert;
        enable |=> modulated_pin_signal == ($past(mixed) ^ $past(result_invert));
    endproperty
    a_invert: assert property (p_invert) else $error("output polarity wrong"); // [RULE_04]

    property p_sw_select;
        enable && modulator_source_select == dsm_pkg::SRC_SOFTWARE
            |-> modulator_level == software_level_source;
    endproperty
    a_sw_select: assert property (p_sw_select) else $error("software level not used"); // [RULE_05]

    property p_reserved;
        enable && modulator_source_select >= dsm_pkg::SRC_FIRST_RESERVE |-> !modulator_level;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code not low"); // [RULE_16]

    property p_disable_ground;
        !enable |-> !high_path && !low_path && modulator_level == software_level_source;
    endproperty
    a_disable_ground: assert property (p_disable_ground) else $error("disabled paths not grounded"); // [RULE_13]

    property p_sync_hold;
        active_carrier == dsm_pkg::DSM_CARRIER_HIGH && high_carrier_sync_enable && high_path
            |=> active_carrier == dsm_pkg::DSM_CARRIER_HIGH;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("high carrier pulse cut"); // [RULE_15]

    property p_sync_hold_low;
        active_carrier == dsm_pkg::DSM_CARRIER_LOW && low_carrier_sync_enable && low_path
            |=> active_carrier == dsm_pkg::DSM_CARRIER_LOW;
    endproperty
    a_sync_hold_low: assert property (p_sync_hold_low) else $error("low carrier pulse cut"); // [RULE_15]

    // A warm reset must leave the source select alone.
    property p_source_keep;
        disable iff (!por_bor_b)
        !(write_access && paddr == dsm_pkg::ADDR_SOURCE) |=> $stable(modulator_source_select);
    endproperty
    a_source_keep: assert property (p_source_keep) else $error("source select lost"); // [RULE_10]

    property p_source_write;
        disable iff (!por_bor_b)
        write_access && paddr == dsm_pkg::ADDR_SOURCE
            |=> modulator_source_select == $past(pwdata[dsm_pkg::SOURCE_WIDTH-1:0]);
    endproperty
    a_source_write: assert property (p_source_write) else $error("source select not stored"); // [RULE_08]

    sequence s_reserved_free;
        enable && modulator_source_select >= dsm_pkg::SRC_FIRST_RESERVE && !high_carrier_sync_enable;
    endsequence

    property p_reserved_low;
        s_reserved_free ##1 s_reserved_free
            |-> active_carrier == dsm_pkg::DSM_CARRIER_LOW && mixed == low_path;
    endproperty
    a_reserved_low: assert property (p_reserved_low) else $error("reserved code not on low carrier"); // [RULE_16]

    property p_mix;
        !high_carrier_sync_enable && !low_carrier_sync_enable
            |=> mixed == ($past(modulator_level) ? high_path : low_path);
    endproperty
    a_mix: assert property (p_mix) else $error("wrong carrier mixed"); // [RULE_12]

    property p_unused_bits;
        s_ctl0_write(8'h6E) |=> modulation_control_0 == (8'h6E & dsm_pkg::MASK_CONTROL_0) ##1
            prdata[31:8] == 24'h00_0000;
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("unused bits stored"); // [RULE_11]

    property p_reset_clear;
        disable iff (1'b0) !rst_b |=> modulation_control_0 == dsm_pkg::RESET_CONTROL_0 &&
                                       modulation_control_1 == dsm_pkg::RESET_CONTROL_1;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("control not cleared by reset"); // [RULE_09]

endmodule : dsm_ctrl

`default_nettype wire

// *** tb/dsm_far_side.sv ***
// Model of the peripherals and pins that feed the carriers and modulator sources.
`timescale 1ns/1ns
`default_nettype none
module dsm_far_side #(
    parameter logic [31:0] SEED = 32'h0000_0001
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Pacing and direct load.
    input  wire logic        freeze,
    input  wire logic        slow,
    input  wire logic        load,
    input  wire logic [27:0] load_val,
    // Signals towards the modulator.
    output logic             high_carrier,
    output logic             low_carrier,
    output logic             pin_in,
    output logic             tx_in,
    output logic             sync_in,
    output logic             spi_in,
    output logic [21:0]      others
);
    integer      seed;
    logic [1:0]  pace;
    logic [27:0] lines;
    initial seed = SEED;
    assign {others, spi_in, sync_in, tx_in, pin_in, low_carrier, high_carrier} = lines;
    // Sources change every cycle, or every fourth cycle when slow; while frozen only a direct load changes them.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lines <= 28'h000_0000;
            pace  <= 2'h0;
        end else if (load) begin
            lines <= load_val;
        end else if (!freeze) begin
            pace <= pace + 2'h1;
            if (!slow || pace == 2'h3) begin
                lines <= 28'($random(seed));
            end
        end
    end
endmodule : dsm_far_side
`default_nettype wire

// *** tb/tb_dsm_ctrl.sv ***
// Self-checking testbench of the data signal modulator control block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("FAIL %s expected %h seen %h", what, exp, got); end end
module tb_dsm_ctrl;
    logic        clk, rst_b, por_bor_b, psel, penable, pwrite, pready, pslverr, out;
    logic        freeze, slow, load, hc, lc, pin, tx, syn, spi, err, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [27:0] load_val, v;
    logic [21:0] others;
    logic [7:0]  c0, c1;
    logic [4:0]  src;
    integer      seed, errors, n_compared;
    assign v = {others, spi, syn, tx, pin, lc, hc};
    dsm_ctrl dut (.clk(clk), .rst_b(rst_b), .por_bor_b(por_bor_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .high_carrier(hc), .low_carrier(lc), .pin_routed_modulator_input(pin),
        .serial_transmit_line(tx), .sync_serial_data_line(syn), .spi_serial_data_line(spi),
        .other_modulator_sources(others), .modulated_pin_signal(out));
    dsm_far_side #(.SEED(32'hc798_4159)) far (.clk(clk), .rst_b(rst_b), .freeze(freeze), .slow(slow),
        .load(load), .load_val(load_val), .high_carrier(hc), .low_carrier(lc), .pin_in(pin), .tx_in(tx),
        .sync_in(syn), .spi_in(spi), .others(others));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic setv(input logic [27:0] w);
        load_val <= w;
        load     <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : setv
    function automatic logic exp_out(logic [7:0] r0, logic [7:0] r1, logic [4:0] s, logic [27:0] w);
        logic m;
        logic car;
        case (s)
            5'h00: m = w[2];
            5'h01: m = r0[0];
            5'h02: m = w[3];
            5'h03: m = w[4];
            5'h04: m = w[5];
            default: m = (s <= 5'h1A) ? w[s + 1] : 1'b0;
        endcase
        car = m ? w[0] ^ r1[5] : w[1] ^ r1[1];
        return r0[7] ? car ^ r0[4] : r0[4];
    endfunction : exp_out
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
    initial begin
        seed = 32'hc798_4159;
        errors = 0;
        n_compared = 0;
        {rst_b, por_bor_b, psel, penable, pwrite, slow, load} = 7'h00;
        freeze = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        load_val = 28'h000_0000;
        repeat (20) @(posedge clk);
        rst_b     <= 1'b1;
        por_bor_b <= 1'b1;
        apb(0, dsm_pkg::ADDR_CONTROL_0, 0);
        `CHK("control_0 reset", 32'h0000_0000, rd)
        apb(0, dsm_pkg::ADDR_CONTROL_1, 0);
        `CHK("control_1 reset", 32'h0000_0000, rd)
        apb(0, dsm_pkg::ADDR_SOURCE, 0);
        `CHK("source reset", 32'h0000_0000, rd)
        `CHK("idle output", 1'b0, out)
        apb(1, 12'h00C, 32'hFFFF_FFFF);
        `CHK("unmapped error", 1'b1, err)
        apb(0, 12'h00C, 0);
        `CHK("unmapped read", 32'h0000_0000, rd)
        apb(1, dsm_pkg::ADDR_CONTROL_0, 32'hFFFF_FF6E);
        apb(0, dsm_pkg::ADDR_CONTROL_0, 0);
        `CHK("control_0 unused", 32'h0000_0000, rd)
        apb(1, dsm_pkg::ADDR_CONTROL_1, 32'hFFFF_FFFF);
        apb(0, dsm_pkg::ADDR_CONTROL_1, 0);
        `CHK("control_1 unused", 32'h0000_0033, rd)
        apb(1, dsm_pkg::ADDR_SOURCE, 32'hFFFF_FFFF);
        apb(0, dsm_pkg::ADDR_SOURCE, 0);
        `CHK("source unused", 32'h0000_001F, rd)
        $display("test registers done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, dsm_pkg::ADDR_CONTROL_1, 0);
        `CHK("control_1 warm reset", 32'h0000_0000, rd)
        apb(0, dsm_pkg::ADDR_SOURCE, 0);
        `CHK("source warm reset", 32'h0000_001F, rd)
        por_bor_b <= 1'b0;
        repeat (2) @(posedge clk);
        por_bor_b <= 1'b1;
        apb(0, dsm_pkg::ADDR_SOURCE, 0);
        `CHK("source power reset", 32'h0000_0000, rd)
        $display("test resets done");
        for (int i = 0; i < 48; i++) begin
            c0 = 8'($random(seed)) & dsm_pkg::MASK_CONTROL_0;
            c1 = 8'($random(seed)) & 8'h22;
            src = (i < 32) ? 5'(i) : 5'($random(seed));
            slow   <= i[0];
            freeze <= 1'b0;
            apb(1, dsm_pkg::ADDR_CONTROL_1, {24'h0, c1});
            apb(1, dsm_pkg::ADDR_SOURCE, {27'h0, src});
            apb(1, dsm_pkg::ADDR_CONTROL_0, {24'h0, c0});
            freeze <= 1'b1;
            repeat (4) @(posedge clk);
            e = exp_out(c0, c1, src, v);
            `CHK("modulated output", e, out)
            apb(0, dsm_pkg::ADDR_CONTROL_0, 0);
            `CHK("output readback", {24'h0, c0 | (8'(e) << 5)}, rd)
            apb(0, dsm_pkg::ADDR_SOURCE, 0);
            `CHK("source kept", {27'h0, src}, rd)
        end
        $display("test mixing done");
        apb(1, dsm_pkg::ADDR_CONTROL_1, 32'h0000_0010);
        apb(1, dsm_pkg::ADDR_SOURCE, 32'h0000_0001);
        apb(1, dsm_pkg::ADDR_CONTROL_0, 32'h0000_0081);
        setv(28'h000_0001);
        `CHK("high carrier active", 1'b1, out)
        apb(1, dsm_pkg::ADDR_CONTROL_0, 32'h0000_0080);
        repeat (4) @(posedge clk);
        `CHK("high pulse held", 1'b1, out)
        setv(28'h000_0000);
        setv(28'h000_0002);
        `CHK("low carrier after pulse", 1'b1, out)
        apb(1, dsm_pkg::ADDR_CONTROL_1, 32'h0000_0001);
        apb(1, dsm_pkg::ADDR_CONTROL_0, 32'h0000_0081);
        repeat (4) @(posedge clk);
        `CHK("low pulse held", 1'b1, out)
        setv(28'h000_0000);
        setv(28'h000_0001);
        `CHK("high carrier after pulse", 1'b1, out)
        $display("test sync done");
        give_verdict();
    end
endmodule : tb_dsm_ctrl
`default_nettype wire
